// File: core/ciu_pkg.sv
// Package of constants and carrier types for the CAN interrupt unit
package ciu_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CIU_ADDR_ENABLE = 8'h2B;
   localparam logic [7:0] CIU_ADDR_FLAGS = 8'h2C;
   localparam logic [7:0] CIU_ENABLE_RST = 8'h00;
   localparam logic [7:0] CIU_FLAGS_RST = 8'h00;
   localparam logic [7:0] CIU_UNMAPPED_RD = 8'h00;

   // ----------------------------------------------------------------
   // Bit positions, shared by both registers
   // ----------------------------------------------------------------
   localparam int CIU_BIT_MSG_ERR = 7;
   localparam int CIU_BIT_WAKEUP = 6;
   localparam int CIU_BIT_ERR_CHG = 5;
   localparam int CIU_BIT_TX2 = 4;
   localparam int CIU_BIT_TX1 = 3;
   localparam int CIU_BIT_TX0 = 2;
   localparam int CIU_BIT_RX1 = 1;
   localparam int CIU_BIT_RX0 = 0;

   // ----------------------------------------------------------------
   // Pending source codes, lower value wins
   // ----------------------------------------------------------------
   localparam logic [2:0] CIU_CODE_NONE = 3'h0;
   localparam logic [2:0] CIU_CODE_ERR = 3'h1;
   localparam logic [2:0] CIU_CODE_WAKE = 3'h2;
   localparam logic [2:0] CIU_CODE_TX0 = 3'h3;
   localparam logic [2:0] CIU_CODE_TX1 = 3'h4;
   localparam logic [2:0] CIU_CODE_TX2 = 3'h5;
   localparam logic [2:0] CIU_CODE_RX0 = 3'h6;
   localparam logic [2:0] CIU_CODE_RX1 = 3'h7;

   // ----------------------------------------------------------------
   // Wake-up pin synchroniser; bus idles recessive (high)
   // ----------------------------------------------------------------
   localparam logic [2:0] CIU_WSYNC_RST = 3'h7;
   localparam logic CIU_WSTABLE_RST = 1'b1;
   localparam logic CIU_INT_N_RST = 1'b1;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] wmask;
   } ciu_reg_req_t;

   typedef struct packed {
      logic msg_err;
      logic [2:0] tx_empty;
      logic [1:0] rx_full;
   } ciu_events_t;

   typedef struct packed {
      logic [7:0] ena;
      logic [7:0] error_condition_register_prev;
      logic [2:0] wsync;
      logic wstable;
      logic int_n;
      logic [2:0] code;
      logic [7:0] rdata;
   } ciu_state_t;

   localparam ciu_state_t CIU_STATE_RST = '{
      ena: CIU_ENABLE_RST,
      error_condition_register_prev: 8'h00,
      wsync: CIU_WSYNC_RST,
      wstable: CIU_WSTABLE_RST,
      int_n: CIU_INT_N_RST,
      code: CIU_CODE_NONE,
      rdata: 8'h00
   };

endpackage

// File: core/ciu_flag_cell.sv
// One sticky interrupt flag with host write and hold-off of clears
`timescale 1ns/1ps
module ciu_flag_cell
   import ciu_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic set_i,
   input wire logic wr_i,
   input wire logic wdata_i,
   input wire logic hold_i,
   output logic flag_o
);

   typedef struct packed {
      logic flag;
   } ciu_cell_t;

   ciu_cell_t s_q;
   ciu_cell_t s_d;

   // ----------------------------------------------------------------
   // Next state: hardware set beats any clear in the same cycle
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (set_i) begin
         s_d.flag = 1'b1; // R16
      end else if (wr_i && wdata_i) begin
         s_d.flag = 1'b1; // R15
      end else if (wr_i && !hold_i) begin
         s_d.flag = 1'b0; // R08 R14
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '{flag: RST_VAL};
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign flag_o = s_q.flag;

endmodule

// File: core/ciu_core.sv
// CAN controller interrupt unit: enable and flag registers, interrupt pin, source code
//
// Operation
// (R01) Message-error enable, bit 7, gates interrupts from reception or transmission errors.
// (R02) Wake-up enable, bit 6, gates interrupts from detected bus activity.
// (R03) Error enable, bit 5, gates interrupts on any error-condition register change.
// (R04) Enable bits 4, 3, 2 gate transmit buffer 2, 1, 0 empty interrupts.
// (R05) Enable bits 1, 0 gate receive buffer 1, 0 full interrupts.
// (R06) Enable register at 2Bh, eight read/write bits, resets to zero.
// (R07) Flag register at 2Ch, eight read/write bits, resets to zero, same layout.
// (R08) A flag at one is pending until the host clears it.
// (R09) Flag bits 4, 3, 2 record transmit buffer 2, 1, 0 empty.
// (R10) Flag bit 5 summarises the error-condition register; host reads that for cause.
// (R11) Flag bits 1, 0 record receive buffer 1, 0 full.
// (R12) Interrupt output stays low while any enabled flag is pending.
// (R13) Three-bit code gives highest enabled pending source; zero means none. Message error (bit 7) has no code here; it alone gives zero.
// (R14) Host clear has no effect while the setting condition persists.
// (R15) Host writing one to a flag creates a pending interrupt if enabled.
// (R16) Events set flags regardless of enables; enables only gate pin and code.
`timescale 1ns/1ps
module ciu_core
   import ciu_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire ciu_reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   input wire ciu_events_t events_i,
   input wire logic [7:0] error_condition_i,
   input wire logic [7:0] src_hold_i,
   input wire logic can_rx_i,
   output logic int_n_o,
   output logic [2:0] pending_source_code_o,
   output logic [7:0] interrupt_flags_o,
   output logic [7:0] interrupt_enable_o
);

   ciu_state_t s_q;
   ciu_state_t s_d;
   logic [7:0] flags_q;
   logic [7:0] set_vec;
   logic [7:0] flag_wr;
   logic [7:0] active;
   logic wake_evt;
   logic err_chg;
   logic wr_ena;
   logic wr_flags;

   // ----------------------------------------------------------------
   // Address decode and source events
   // ----------------------------------------------------------------
   always_comb begin
      wr_ena = 1'b0;
      wr_flags = 1'b0;
      if (reg_req_i.wr && reg_req_i.addr == CIU_ADDR_ENABLE) begin
         wr_ena = 1'b1; // R06
      end else if (reg_req_i.wr && reg_req_i.addr == CIU_ADDR_FLAGS) begin
         wr_flags = 1'b1; // R07
      end
   end

   // Bus activity is a falling edge of the filtered pin, so noise on one
   // sample cannot wake the controller
   assign wake_evt = s_q.wstable && (s_q.wsync[1] == s_q.wsync[2]) && !s_q.wsync[2]; // R02
   assign err_chg = error_condition_i != s_q.error_condition_register_prev; // R03 R10

   always_comb begin
      set_vec = 8'h00;
      set_vec[CIU_BIT_MSG_ERR] = events_i.msg_err; // R01
      set_vec[CIU_BIT_WAKEUP] = wake_evt; // R02
      set_vec[CIU_BIT_ERR_CHG] = err_chg; // R03 R10
      set_vec[CIU_BIT_TX2] = events_i.tx_empty[2]; // R04 R09
      set_vec[CIU_BIT_TX1] = events_i.tx_empty[1]; // R04 R09
      set_vec[CIU_BIT_TX0] = events_i.tx_empty[0]; // R04 R09
      set_vec[CIU_BIT_RX1] = events_i.rx_full[1]; // R05 R11
      set_vec[CIU_BIT_RX0] = events_i.rx_full[0]; // R05 R11
   end

   // Bit-modify style mask avoids losing a flag that rises mid-write
   assign flag_wr = wr_flags ? reg_req_i.wmask : 8'h00;

   // ----------------------------------------------------------------
   // Flag bits
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 8; g++) begin : g_flag
      ciu_flag_cell #(
         .RST_VAL(CIU_FLAGS_RST[g])
      ) u_cell (
         .ref_clk_i(ref_clk_i),
         .arst_n_i(arst_n_i),
         .ce_i(ce_i),
         .set_i(set_vec[g]),
         .wr_i(flag_wr[g]),
         .wdata_i(reg_req_i.wdata[g]),
         .hold_i(src_hold_i[g]),
         .flag_o(flags_q[g])
      );
   end

   assign active = flags_q & s_q.ena; // R16

   // ----------------------------------------------------------------
   // State update
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.wsync = {s_q.wsync[1:0], can_rx_i};
      if (s_q.wsync[1] == s_q.wsync[2]) begin
         s_d.wstable = s_q.wsync[2];
      end
      s_d.error_condition_register_prev = error_condition_i;
      if (wr_ena) begin
         s_d.ena = (s_q.ena & ~reg_req_i.wmask) | (reg_req_i.wdata & reg_req_i.wmask); // R06
      end
      s_d.int_n = ~(|active); // R12
      if (active[CIU_BIT_ERR_CHG]) begin // R13
         s_d.code = CIU_CODE_ERR;
      end else if (active[CIU_BIT_WAKEUP]) begin
         s_d.code = CIU_CODE_WAKE;
      end else if (active[CIU_BIT_TX0]) begin
         s_d.code = CIU_CODE_TX0;
      end else if (active[CIU_BIT_TX1]) begin
         s_d.code = CIU_CODE_TX1;
      end else if (active[CIU_BIT_TX2]) begin
         s_d.code = CIU_CODE_TX2;
      end else if (active[CIU_BIT_RX0]) begin
         s_d.code = CIU_CODE_RX0;
      end else if (active[CIU_BIT_RX1]) begin
         s_d.code = CIU_CODE_RX1;
      end else begin
         s_d.code = CIU_CODE_NONE;
      end
      if (reg_req_i.rd) begin
         if (reg_req_i.addr == CIU_ADDR_ENABLE) begin
            s_d.rdata = s_q.ena; // R06
         end else if (reg_req_i.addr == CIU_ADDR_FLAGS) begin
            s_d.rdata = flags_q; // R07 R08
         end else begin
            s_d.rdata = CIU_UNMAPPED_RD;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= CIU_STATE_RST;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o = s_q.rdata;
   assign int_n_o = s_q.int_n;
   assign pending_source_code_o = s_q.code;
   assign interrupt_flags_o = flags_q;
   assign interrupt_enable_o = s_q.ena;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   a_int_asserts: assert property (ce_i && (|active) |=> !int_n_o) // R12
      else $error("interrupt pin not low with enabled pending flag");

   a_int_releases: assert property (ce_i && !(|active) |=> int_n_o) // R12
      else $error("interrupt pin low with nothing enabled pending");

   a_code_error_top: assert property (ce_i && active[CIU_BIT_ERR_CHG] // R13
      |=> pending_source_code_o == CIU_CODE_ERR)
      else $error("error source not reported first");

   a_code_rx1_low: assert property (ce_i && active == 8'h02 // R13
      |=> pending_source_code_o == CIU_CODE_RX1)
      else $error("receive buffer 1 code wrong");

   a_msg_err_uncoded: assert property (ce_i && active == 8'h80 // R01
      |=> pending_source_code_o == CIU_CODE_NONE && !int_n_o)
      else $error("message error handled wrongly");

   a_event_sets_flag: assert property (ce_i && (|set_vec) // R16
      |=> (flags_q & $past(set_vec)) == $past(set_vec))
      else $error("source event did not set its flag");

   a_hold_blocks_clear: assert property (ce_i && wr_flags && !(|set_vec) // R14
      |=> (flags_q & $past(src_hold_i & flags_q)) == $past(src_hold_i & flags_q))
      else $error("held flag was cleared");

   a_host_sets_flag: assert property (ce_i && wr_flags // R15
      |=> (flags_q & $past(reg_req_i.wdata & reg_req_i.wmask))
          == $past(reg_req_i.wdata & reg_req_i.wmask))
      else $error("host write of one did not set flag");

   a_host_set_irq: assert property (ce_i && wr_flags && (|(reg_req_i.wdata // R15
      & reg_req_i.wmask & s_q.ena)) && !wr_ena ##1 ce_i |=> !int_n_o)
      else $error("host-set enabled flag gave no interrupt");

   a_enable_write: assert property (ce_i && wr_ena // R06
      |=> interrupt_enable_o == $past((s_q.ena & ~reg_req_i.wmask)
          | (reg_req_i.wdata & reg_req_i.wmask)))
      else $error("enable register write lost");

   a_read_flags: assert property (ce_i && reg_req_i.rd && reg_req_i.addr == CIU_ADDR_FLAGS // R07
      |=> reg_rdata_o == $past(flags_q))
      else $error("flag register readback wrong");

   // Unheld clear with no competing event must land at the same edge
   a_clear_lands: assert property (ce_i && wr_flags && !(|set_vec) // R08
      |=> (interrupt_flags_o & $past(reg_req_i.wmask & ~reg_req_i.wdata
          & ~src_hold_i)) == 8'h00)
      else $error("unheld flag clear did not land");

   a_code_wake: assert property (ce_i && active[CIU_BIT_WAKEUP] && !active[CIU_BIT_ERR_CHG] // R13
      |=> pending_source_code_o == CIU_CODE_WAKE)
      else $error("wake-up source code wrong");

   a_freeze_holds: assert property (!ce_i // R08
      |=> $stable(interrupt_flags_o) && $stable(interrupt_enable_o) && $stable(int_n_o))
      else $error("state moved while clock enable low");

endmodule

// File: dv/ciu_host_model.sv
// Host model issuing register requests to the CAN interrupt unit
`timescale 1ns/1ps
module ciu_host_model
   import ciu_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic [7:0] reg_rdata_i,
   output ciu_reg_req_t reg_req_o
);
   initial begin
      reg_req_o = '0;
   end

   // Request held from one falling edge to the next, so exactly one rising edge takes it
   task automatic acc(input logic w, input logic [7:0] a, d, m, output logic [7:0] q);
      @(negedge ref_clk_i);
      reg_req_o = '{wr: w, rd: !w, addr: a, wdata: d, wmask: m};
      @(negedge ref_clk_i);
      q = reg_rdata_i;
      reg_req_o = '0;
   endtask

   // Clearing a flag is a masked write of zero
   task automatic wr(input logic [7:0] a, d, m);
      logic [7:0] q;
      acc(1'b1, a, d, m, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      acc(1'b0, a, 8'h00, 8'h00, q);
   endtask
endmodule

// File: dv/ciu_core_bench.sv
// Self-checking bench for the CAN interrupt unit
`timescale 1ns/1ps
module ciu_core_bench
   import ciu_pkg::*;
();
   logic ref_clk_i, arst_n_i, ce_i, can_rx_i, int_n_o;
   ciu_reg_req_t req;
   ciu_events_t ev;
   logic [7:0] ec, hold, rdata, flags, ena, q;
   logic [2:0] code;
   int n_fail = 0;
   int samples_checked = 0;
   localparam int ORD [7] = '{5, 6, 2, 3, 4, 0, 1};

   ciu_core uut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
      .reg_req_i(req), .reg_rdata_o(rdata), .events_i(ev), .error_condition_i(ec),
      .src_hold_i(hold), .can_rx_i(can_rx_i), .int_n_o(int_n_o),
      .pending_source_code_o(code), .interrupt_flags_o(flags), .interrupt_enable_o(ena));

   ciu_host_model host (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_req_o(req));

   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic close_out;
      if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Lowest code wins; bit 7 never shows in the code
   function automatic logic [2:0] exp_code(input logic [7:0] p);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 6; i >= 0; i--) if (p[ORD[i]]) c = 3'(i + 1);
      return c;
   endfunction

   task automatic see(input logic [7:0] f, e);
      @(negedge ref_clk_i);
      chk(flags, f);
      chk(ena, e);
      chk({7'h00, int_n_o}, {7'h00, ~|(f & e)});
      chk({5'h00, code}, {5'h00, exp_code(f & e)});
   endtask

   task automatic rdc(input logic [7:0] a, exp);
      host.rd(a, q);
      chk(q, exp);
   endtask

   // Raises the source behind flag bit b; the wake pin is held low past the synchroniser
   task automatic fire(input int b);
      @(negedge ref_clk_i);
      if (b == 5) ec = ec ^ 8'h10;
      else if (b == 6) can_rx_i = 1'b0;
      else ev = ciu_events_t'(6'h01 << ((b == 7) ? 5 : b));
      @(negedge ref_clk_i);
      ev = '0;
      if (b == 6) begin
         repeat (8) @(negedge ref_clk_i);
         can_rx_i = 1'b1;
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      see(8'h00, 8'h00);
      rdc(CIU_ADDR_ENABLE, 8'h00);
      rdc(CIU_ADDR_FLAGS, 8'h00);
   endtask

   task automatic t_enable;
      host.wr(CIU_ADDR_ENABLE, 8'hA5, 8'hFF);
      rdc(CIU_ADDR_ENABLE, 8'hA5);
      host.wr(CIU_ADDR_ENABLE, 8'hFF, 8'h0F);
      host.wr(8'h2A, 8'hFF, 8'hFF);
      rdc(8'h2A, 8'h00);
      rdc(CIU_ADDR_ENABLE, 8'hAF);
      host.wr(CIU_ADDR_ENABLE, 8'h00, 8'hFF);
   endtask

   // Each source first disabled, then enabled, then cleared
   task automatic t_sources;
      logic [7:0] m;
      for (int b = 0; b < 8; b++) begin
         m = 8'h01 << b;
         fire(b);
         see(m, 8'h00);
         host.wr(CIU_ADDR_ENABLE, m, 8'hFF);
         see(m, m);
         rdc(CIU_ADDR_FLAGS, m);
         host.wr(CIU_ADDR_FLAGS, 8'h00, m);
         see(8'h00, m);
         host.wr(CIU_ADDR_ENABLE, 8'h00, 8'hFF);
      end
   endtask

   // Host sets every flag, then clears them in priority order
   task automatic t_priority;
      logic [7:0] f;
      f = 8'hFF;
      host.wr(CIU_ADDR_ENABLE, 8'hFF, 8'hFF);
      host.wr(CIU_ADDR_FLAGS, 8'hFF, 8'hFF);
      see(f, 8'hFF);
      for (int i = 0; i < 7; i++) begin
         f[ORD[i]] = 1'b0;
         host.wr(CIU_ADDR_FLAGS, 8'h00, 8'h01 << ORD[i]);
         see(f, 8'hFF);
      end
      host.wr(CIU_ADDR_FLAGS, 8'h00, 8'h80);
      see(8'h00, 8'hFF);
   endtask

   task automatic t_hold;
      hold = 8'h02;
      host.wr(CIU_ADDR_FLAGS, 8'h02, 8'h02);
      host.wr(CIU_ADDR_FLAGS, 8'h00, 8'h02);
      see(8'h02, 8'hFF);
      hold = 8'h00;
      host.wr(CIU_ADDR_FLAGS, 8'h00, 8'h02);
      see(8'h00, 8'hFF);
   endtask

   // Clock enable low: a pulsed event and a write are both lost
   task automatic t_freeze;
      ce_i = 1'b0;
      host.wr(CIU_ADDR_ENABLE, 8'h00, 8'hFF);
      fire(0);
      see(8'h00, 8'hFF);
      ce_i = 1'b1;
      fire(0);
      see(8'h01, 8'hFF);
      host.wr(CIU_ADDR_FLAGS, 8'h00, 8'h01);
      see(8'h00, 8'hFF);
   endtask

   initial begin
      arst_n_i = 1'b0;
      ce_i = 1'b1;
      can_rx_i = 1'b1;
      ev = '0;
      ec = 8'h00;
      hold = 8'h00;
      repeat (5) @(negedge ref_clk_i);
      arst_n_i = 1'b1;
      t_reset;
      t_enable;
      t_sources;
      t_priority;
      t_hold;
      t_freeze;
      close_out;
   end

   // A hang is cut short well inside the run budget
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      n_fail++;
      close_out;
   end
endmodule
